// File: logic/see_map.vh
/*
 file holds: opcodes, status bit positions, guard codes and timing constants
 of the serial eeprom command front end.
 assumes: included by bare name from the front end design file only.
*/
`ifndef SEE_MAP_VH
`define SEE_MAP_VH

// opcodes with the don't-care bit 3 forced to zero
`define SEE_OP_MASK        8'hF7
`define SEE_OP_SET_LATCH   8'h06
`define SEE_OP_CLR_LATCH   8'h04
`define SEE_OP_STAT_READ   8'h05
`define SEE_OP_STAT_WRITE  8'h01
`define SEE_OP_READ        8'h03
`define SEE_OP_WRITE       8'h02
`define SEE_OP_ID_READ     8'h83
`define SEE_OP_ID_WRITE    8'h82

// status byte bit positions
`define SEE_ST_BUSY        0
`define SEE_ST_LATCH       1
`define SEE_ST_GUARD_LO    2
`define SEE_ST_GUARD_HI    3
`define SEE_ST_ARM         7

// guard codes
`define SEE_GUARD_NONE     2'h0
`define SEE_GUARD_QUARTER  2'h1
`define SEE_GUARD_HALF     2'h2
`define SEE_GUARD_ALL      2'h3
`define SEE_QUARTER_BASE   8'hC0
`define SEE_HALF_BASE      8'h80

// address bit that selects lock functions on id opcodes
`define SEE_ADDR_LOCK_BIT  7
// lock data byte bit that must be one
`define SEE_LOCK_DATA_BIT  1
// page offset mask and page base mask
`define SEE_PAGE_OFS       8'h0F
`define SEE_PAGE_BASE      8'hF0

// erased cell value and reset values
`define SEE_ERASED         8'hFF
`define SEE_BYTE_ZERO      8'h00
`define SEE_BIT_LAST       3'h7
`define SEE_BIT_FIRST      3'h0

// self-timed write cycle: 5 ms at 10 MHz
`define SEE_TWR_US         5000
`define SEE_CLK_MHZ        10
`define SEE_TWR_CYCLES     (`SEE_TWR_US * `SEE_CLK_MHZ)

`endif

// File: logic/see_sync.v
/*
 file holds: two-flop synchroniser for one pin level.
 assumes: input is asynchronous to clk; reset asynchronous active low.
*/
`timescale 1ns/1ps
module see_sync (
   // clock and reset
   input  wire clk,
   input  wire rstn,
   // level in and out
   input  wire din,
   output reg  dout
);
   reg stage1;

   // first stage is read only by the second
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage1 <= 1'b1;
         dout   <= 1'b1;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule // see_sync

// File: logic/see_timer.v
/*
 file holds: down counter for the self-timed write cycle.
 assumes: start is a one-cycle pulse on clk; length is constant.
*/
`timescale 1ns/1ps
module see_timer #(
   parameter [31:0] LENGTH = 32'd50000
) (
   // clock and reset
   input  wire clk,
   input  wire rstn,
   // control
   input  wire start,
   output wire done,
   output wire running
);
   reg [31:0] count;

   // counts down from start, done pulses at the last cycle
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count <= 32'h0;
      end else if (start) begin
         count <= LENGTH;
      end else if (count != 32'h0) begin
         count <= count - 32'h1;
      end
   end

   assign running = (count != 32'h0);
   assign done    = (count == 32'h1);
endmodule // see_timer

// File: logic/see_front.v
/*
 file holds: serial command front end of a 256-byte eeprom with a 16-byte
 identification page: opcode decode, latch, status, array and id access.
 assumes: CLK at 10 MHz samples the serial pins; SCK runs far slower.
*/
// Behaviour
// - low chip select enables; one SI bit sampled per rising SCK edge.
// - opcode first, then address and data, all MSB first.
// - SO changes on each falling SCK edge during output.
// - chip select rise ends the transfer and starts the operation.
// - opcodes 0000X110 set and 0000X100 clear the write latch.
// - while busy, only status read is accepted.
// - status read repeats the 8 status bits while selected.
// - status write acts only with latch set and no hardware protection.
// - status write stores only guard bits and arm bit.
// - status bits except busy keep old values until the cycle ends.
// - arm bit may clear only while protect pin is high.
// - array read streams upward and wraps to address zero.
// - chip select rise ends an array read at once.
// - array write loads bytes into the addressed 16-byte page.
// - write address wraps inside the page after its last byte.
// - more than 16 bytes keeps only the final 16.
// - protected block rejects writes; others need the write latch.
// - hardware protection does not block array writes.
// - latch clears at reset and after clear, status write, array write.
// - id opcodes 1000X011 and 1000X010 also serve lock read and lock.
// - id access needs A7 zero; A3:A0 select the byte.
// - status: busy bit0, latch bit1, guard bits 2-3, arm bit7.
// - guard 01 protects C0-FF, 10 80-FF, 11 all.
// - hardware protection is protect pin low with arm set.
`timescale 1ns/1ps
`include "see_map.vh"
module see_front #(
   parameter [31:0] TWR_CYCLES = `SEE_TWR_CYCLES
) (
   // clock and reset
   input  wire       CLK,
   input  wire       RSTN,
   // serial pins
   input  wire       CS_N,
   input  wire       SCK,
   input  wire       SI,
   output reg        SO,
   output reg        SO_OE,
   // write protect pin
   input  wire       WP_N,
   // state seen from outside
   output wire       BUSY,
   output wire       ID_LOCKED
);
   localparam [4:0] ST_CMD   = 5'h01;
   localparam [4:0] ST_ADDR  = 5'h02;
   localparam [4:0] ST_DATA  = 5'h04;
   localparam [4:0] ST_OUT   = 5'h08;
   localparam [4:0] ST_IGN   = 5'h10;

   // pending operation kinds
   localparam [2:0] OP_NONE  = 3'h0;
   localparam [2:0] OP_STAT  = 3'h1;
   localparam [2:0] OP_ARRAY = 3'h2;
   localparam [2:0] OP_ID    = 3'h3;
   localparam [2:0] OP_LOCK  = 3'h4;

   wire       cs_s;
   wire       sck_s;
   wire       si_s;
   wire       wp_s;
   reg        sck_d;
   reg        cs_d;
   reg  [4:0] state;
   reg  [2:0] bit_cnt;
   reg  [7:0] shreg;
   reg  [7:0] opcode;
   reg  [7:0] addr;
   reg  [7:0] out_byte;
   reg        byte_done;
   reg        latch;
   reg  [1:0] guard;
   reg        arm;
   reg        lock;
   reg  [2:0] pend;
   reg  [7:0] pend_stat;
   reg  [7:0] mem [0:255];
   reg  [7:0] idp [0:15];
   reg  [7:0] pbuf [0:15];
   reg [15:0] pvalid;
   reg  [7:0] pbase;
   reg  [4:0] wr_idx;
   integer    i, j;

   wire       busy_run;
   wire       busy_done;
   wire       rise      = sck_s & ~sck_d;
   wire       fall      = ~sck_s & sck_d;
   wire       cs_rise   = cs_s & ~cs_d;
   wire       selected  = ~cs_s;
   wire [7:0] op_m      = opcode & `SEE_OP_MASK;
   wire [7:0] next_sh   = {shreg[6:0], si_s};
   wire       hw_prot   = ~wp_s & arm;
   wire       start_wr  = cs_rise & byte_done & ~busy_run & (pend != OP_NONE);
   wire [7:0] status_b;

   // sync of the outside pins
   see_sync u_cs  (.clk(CLK), .rstn(RSTN), .din(CS_N), .dout(cs_s));
   see_sync u_sck (.clk(CLK), .rstn(RSTN), .din(SCK),  .dout(sck_s));
   see_sync u_si  (.clk(CLK), .rstn(RSTN), .din(SI),   .dout(si_s));
   see_sync u_wp  (.clk(CLK), .rstn(RSTN), .din(WP_N), .dout(wp_s));

   // self-timed write cycle
   see_timer #(.LENGTH(TWR_CYCLES)) u_twr (
      .clk     (CLK),
      .rstn    (RSTN),
      .start   (start_wr),
      .done    (busy_done),
      .running (busy_run)
   );

   // status byte; during a cycle only busy changes
   assign status_b = {arm, 3'h0, guard, latch, busy_run};
   assign BUSY      = busy_run;
   assign ID_LOCKED = lock;

   // protected-block test for an array address
   function guarded;
      input [1:0] g;
      input [7:0] a;
      begin
         case (g)
            `SEE_GUARD_QUARTER: guarded = (a >= `SEE_QUARTER_BASE);
            `SEE_GUARD_HALF:    guarded = (a >= `SEE_HALF_BASE);
            `SEE_GUARD_ALL:     guarded = 1'b1;
            default:            guarded = 1'b0;
         endcase
      end
   endfunction

   // edge history of the synchronised pins
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sck_d <= 1'b1;                                 // matches sync reset, no false edge
         cs_d  <= 1'b1;
      end else begin
         sck_d <= sck_s;
         cs_d  <= cs_s;
      end
   end

   // bit shifter, state machine and pending operation capture
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state     <= ST_CMD;
         bit_cnt   <= `SEE_BIT_FIRST;
         shreg     <= `SEE_BYTE_ZERO;
         opcode    <= `SEE_BYTE_ZERO;
         addr      <= `SEE_BYTE_ZERO;
         byte_done <= 1'b0;
         pend      <= OP_NONE;
         pend_stat <= `SEE_BYTE_ZERO;
         pbase     <= `SEE_BYTE_ZERO;
         pvalid    <= 16'h0;
         wr_idx    <= 5'h0;
      end else if (!selected) begin
         // deselected: abort any shift, drop unfinished bytes
         state     <= ST_CMD;
         bit_cnt   <= `SEE_BIT_FIRST;
         byte_done <= 1'b0;
         // a cut frame drops its operation, never one already running
         if (cs_rise && !byte_done && !busy_run)
            pend <= OP_NONE;
         if (busy_done)
            pend <= OP_NONE;
      end else if (rise) begin
         if (busy_done)
            pend <= OP_NONE;
         shreg   <= next_sh;
         bit_cnt <= bit_cnt + 3'h1;
         byte_done <= 1'b0;
         if (bit_cnt == `SEE_BIT_LAST) begin
            byte_done <= 1'b1;
            case (state)
               ST_CMD: begin
                  opcode <= next_sh;
                  if (!busy_run)
                     pvalid <= 16'h0;                   // no stale bytes from a refused frame
                  if (busy_run &&
                      ((next_sh & `SEE_OP_MASK) != `SEE_OP_STAT_READ))
                     state <= ST_IGN;
                  else if ((next_sh & `SEE_OP_MASK) == `SEE_OP_STAT_READ)
                     state <= ST_OUT;
                  else if ((next_sh & `SEE_OP_MASK) == `SEE_OP_STAT_WRITE)
                     state <= ST_DATA;
                  else if (((next_sh & `SEE_OP_MASK) == `SEE_OP_READ) ||
                           ((next_sh & `SEE_OP_MASK) == `SEE_OP_WRITE) ||
                           ((next_sh & `SEE_OP_MASK) == `SEE_OP_ID_READ) ||
                           ((next_sh & `SEE_OP_MASK) == `SEE_OP_ID_WRITE))
                     state <= ST_ADDR;
                  else
                     state <= ST_IGN;
               end
               ST_ADDR: begin
                  addr   <= next_sh;
                  pbase  <= next_sh & `SEE_PAGE_BASE;
                  wr_idx <= {1'b0, next_sh[3:0]};
                  if ((op_m == `SEE_OP_READ) || (op_m == `SEE_OP_ID_READ))
                     state <= ST_OUT;
                  else
                     state <= ST_DATA;
               end
               ST_DATA: begin
                  if (op_m == `SEE_OP_STAT_WRITE) begin
                     if (latch && !hw_prot) begin
                        pend      <= OP_STAT;
                        pend_stat <= next_sh;
                     end
                     state <= ST_IGN;
                  end else if (op_m == `SEE_OP_WRITE) begin
                     pbuf[wr_idx[3:0]]   <= next_sh;
                     pvalid[wr_idx[3:0]] <= 1'b1;
                     wr_idx <= {1'b0, wr_idx[3:0] + 4'h1};
                     // hw_prot not consulted for the array
                     if (latch && !guarded(guard, pbase | {4'h0, wr_idx[3:0]}))
                        pend <= OP_ARRAY;
                  end else if (!addr[`SEE_ADDR_LOCK_BIT]) begin
                     pbuf[wr_idx[3:0]]   <= next_sh;
                     pvalid[wr_idx[3:0]] <= 1'b1;
                     wr_idx <= {1'b0, wr_idx[3:0] + 4'h1};
                     if (latch && !lock)
                        pend <= OP_ID;
                  end else begin
                     if (latch && !lock && next_sh[`SEE_LOCK_DATA_BIT] &&
                         (guard != `SEE_GUARD_ALL))
                        pend <= OP_LOCK;
                     state <= ST_IGN;
                  end
               end
               ST_OUT:  addr  <= (op_m == `SEE_OP_READ) ? addr + 8'h1 :
                                 {addr[7:4], addr[3:0] + 4'h1};
               default: state <= state;
            endcase
         end
      end else if (busy_done)
         pend <= OP_NONE;
   end

   // storage update, latch and status at command end or cycle end
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         latch <= 1'b0;
         guard <= `SEE_GUARD_NONE;
         arm   <= 1'b0;
         lock  <= 1'b0;
      end else begin
         if (selected && rise && (bit_cnt == `SEE_BIT_LAST) && (state == ST_CMD)
             && !busy_run) begin
            if ((next_sh & `SEE_OP_MASK) == `SEE_OP_SET_LATCH)
               latch <= 1'b1;
            else if ((next_sh & `SEE_OP_MASK) == `SEE_OP_CLR_LATCH)
               latch <= 1'b0;
         end
         if (busy_done && ((pend == OP_STAT) || (pend == OP_ARRAY)))
            latch <= 1'b0;
         if (busy_done) begin
            case (pend)
               OP_STAT: begin
                  guard <= {pend_stat[`SEE_ST_GUARD_HI], pend_stat[`SEE_ST_GUARD_LO]};
                  if (pend_stat[`SEE_ST_ARM] || wp_s)
                     arm <= pend_stat[`SEE_ST_ARM];
               end
               OP_ARRAY: begin
                  for (i = 0; i < 16; i = i + 1)
                     if (pvalid[i] && !guarded(guard, pbase | i[7:0]))
                        mem[pbase | i[7:0]] <= pbuf[i];
               end
               OP_ID: begin
                  for (i = 0; i < 16; i = i + 1)
                     if (pvalid[i])
                        idp[i] <= pbuf[i];
               end
               OP_LOCK: lock <= 1'b1;
               default: lock <= lock;
            endcase
         end
      end
   end

   // output byte and SO driver, changes on the falling SCK edge
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         SO       <= 1'b0;
         SO_OE    <= 1'b0;
         out_byte <= `SEE_BYTE_ZERO;
      end else if (!selected || (state != ST_OUT)) begin
         SO_OE <= 1'b0;
         SO    <= 1'b0;
         if (selected && rise && (bit_cnt == `SEE_BIT_LAST)) begin
            if (state == ST_CMD) begin
               out_byte <= status_b;
            end else if (state == ST_ADDR) begin
               if (op_m == `SEE_OP_READ)
                  out_byte <= mem[next_sh];
               else if (next_sh[`SEE_ADDR_LOCK_BIT])
                  out_byte <= {7'h0, lock};
               else
                  out_byte <= idp[next_sh[3:0]];
            end
         end
      end else if (fall) begin
         SO_OE <= 1'b1;
         SO    <= out_byte[`SEE_BIT_LAST - bit_cnt];
         if (bit_cnt == `SEE_BIT_LAST) begin
            // reload for the next byte
            if (op_m == `SEE_OP_STAT_READ)
               out_byte <= status_b;
            else if (op_m == `SEE_OP_READ)
               out_byte <= mem[addr + 8'h1];
            else if (addr[`SEE_ADDR_LOCK_BIT])
               out_byte <= {7'h0, lock};
            else
               out_byte <= idp[addr[3:0] + 4'h1];
         end
      end
   end

   // array and id page start erased
   initial begin
      for (j = 0; j < 256; j = j + 1)
         mem[j] = `SEE_ERASED;
      for (j = 0; j < 16; j = j + 1)
         idp[j] = `SEE_ERASED;
   end
endmodule // see_front

// File: sim/see_front_props.sv
/*
 file holds: pin timing checker for the serial eeprom command front end.
 assumes: bound to see_front; the serial clock runs far slower than CLK.
*/
`timescale 1ns/1ps
module see_front_props #(
   parameter [31:0] TWR_CYCLES = 32'd50
) (
   // clock and reset
   input wire CLK,
   input wire RSTN,
   // serial pins and protect pin
   input wire CS_N,
   input wire SCK,
   input wire SI,
   input wire SO,
   input wire SO_OE,
   input wire WP_N,
   // state
   input wire BUSY,
   input wire ID_LOCKED
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   reg [31:0] busy_cnt;
   // length of the current busy stretch
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) busy_cnt <= 32'h0;
      else busy_cnt <= BUSY ? busy_cnt + 32'h1 : 32'h0;
   end
   property p_idle_quiet; CS_N [*4] |-> !SO_OE; endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("output on while deselected");
   property p_oe_late; $rose(SO_OE) |-> !CS_N && $past(CS_N, 8) == 1'b0; endproperty
   a_oe_late: assert property (p_oe_late) else $error("output before opcode");
   property p_oe_fall; $rose(SO_OE) |-> !SCK; endproperty
   a_oe_fall: assert property (p_oe_fall) else $error("output start off the fall");
   property p_so_fall; SO_OE && $changed(SO) |-> !SCK; endproperty
   a_so_fall: assert property (p_so_fall) else $error("data out moved with clock high");
   property p_busy_cs; $rose(BUSY) |-> $past(CS_N) && $past(CS_N, 2); endproperty
   a_busy_cs: assert property (p_busy_cs) else $error("busy before deselect");
   property p_busy_hold; $rose(BUSY) |-> BUSY [*8]; endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
   property p_busy_len; $fell(BUSY) |-> busy_cnt == TWR_CYCLES; endproperty
   a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
   property p_lock_keep; $past(ID_LOCKED) |-> ID_LOCKED; endproperty
   a_lock_keep: assert property (p_lock_keep) else $error("id lock released");
   c_busy: cover property ($rose(BUSY));
   c_out: cover property ($rose(SO_OE));
   c_lock: cover property ($rose(ID_LOCKED));
endmodule // see_front_props

// File: sim/see_master.sv
/*
 file holds: serial bus master model, mode 0, clock idle low.
 assumes: clk is the 10 MHz bench clock; half serial period is 4 cycles.
*/
`timescale 1ns/1ps
module see_master (
   input  wire clk,
   output reg  cs_n,
   output reg  sck,
   output reg  si,
   input  wire so
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // one byte msb first; data in set with clock low, data out taken at rise
   task xbyte(input [7:0] d, output [7:0] q);
      integer i;
      begin
         cs_n = 1'b0;
         for (i = 7; i >= 0; i = i - 1) begin
            si = d[i];
            repeat (4) @(negedge clk);
            q[i] = so;
            sck = 1'b1;
            repeat (4) @(negedge clk);
            sck = 1'b0;
         end
      end
   endtask
   // deselect after the last fall, before any further rise
   task stop;
      begin
         repeat (4) @(negedge clk);
         cs_n = 1'b1;
         si = ~si;
         repeat (8) @(negedge clk);
      end
   endtask
endmodule // see_master

// File: sim/see_front_test.sv
/*
 file holds: self-checking bench of the serial eeprom command front end.
 assumes: see_front, see_master and see_front_props are compiled first.
*/
`timescale 1ns/1ps
module see_front_test;
   localparam int TWR = 600;
   reg         clk;
   reg         rstn;
   reg         wp_n;
   wire        cs_n, sck, si, so, so_oe, busy, id_locked;
   integer     fails = 0;
   integer     tests_run = 0;
   integer     cyc = 0;
   integer     i;
   reg [7:0]   q;
   reg [7:0]   got [0:15];
   reg [7:0]   ref_pg [0:15];
   see_front #(.TWR_CYCLES(TWR)) dut (.CLK(clk), .RSTN(rstn), .CS_N(cs_n), .SCK(sck), .SI(si),
      .SO(so), .SO_OE(so_oe), .WP_N(wp_n), .BUSY(busy), .ID_LOCKED(id_locked));
   see_master mst (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so));
   // clock and hang guard
   always #50 clk = ~clk;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         fails = fails + 1;
         conclude;
      end
   end
   task cmp(input [7:0] g, input [7:0] e);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            fails = fails + 1;
            $display("Error at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   task conclude;
      begin
         $display("fails=%0d tests_run=%0d", fails, tests_run);
         if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // wait out a write cycle under a bound
   task idle;
      integer k;
      begin
         for (k = 0; k < 1000 && busy !== 1'b0; k = k + 1) @(negedge clk);
         cmp({7'h00, busy}, 8'h00);
      end
   endtask
   task wr(input [7:0] c, input [7:0] a, input [7:0] d, input integer n);
      begin
         mst.xbyte(c, q);
         if (n > 1) mst.xbyte(a, q);
         if (n > 2) mst.xbyte(d, q);
         mst.stop;
         idle;
      end
   endtask
   task wen;
      wr(8'h06, 8'h00, 8'h00, 1);
   endtask
   // opcode, address, then n bytes; q holds what came during the address
   task rd(input [7:0] c, input [7:0] a, input integer n);
      integer k;
      begin
         mst.xbyte(c, q);
         mst.xbyte(a, q);
         for (k = 0; k < n; k = k + 1) mst.xbyte(8'h00, got[k]);
         mst.stop;
      end
   endtask
   task t_latch;
      begin
         rd(8'h05, 8'h00, 1);
         cmp(q, 8'h00);
         wr(8'h0E, 8'h00, 8'h00, 1);
         rd(8'h05, 8'h00, 1);
         cmp(q, 8'h02);
         cmp(got[0], 8'h02);
         wr(8'h0C, 8'h00, 8'h00, 1);
         rd(8'h05, 8'h00, 1);
         cmp(q, 8'h00);
      end
   endtask
   task t_write;
      begin
         wen;
         mst.xbyte(8'h02, q);
         mst.xbyte(8'h00, q);
         mst.xbyte(8'h5A, q);
         mst.stop;
         cmp({7'h00, busy}, 8'h01);
         rd(8'h05, 8'h00, 0);
         cmp(q, 8'h03);
         rd(8'h03, 8'h00, 1);
         cmp({7'h00, so_oe}, 8'h00);
         cmp(got[0], 8'h00);
         idle;
         rd(8'h05, 8'h00, 0);
         cmp(q, 8'h00);
         wr(8'h02, 8'h10, 8'h77, 3);
         rd(8'h03, 8'h10, 1);
         cmp(got[0], 8'hFF);
      end
   endtask
   task t_page;
      begin
         wen;
         mst.xbyte(8'h02, q);
         mst.xbyte(8'h1E, q);
         for (i = 0; i < 18; i = i + 1) begin
            mst.xbyte(8'(i + 1), q);
            ref_pg[(14 + i) % 16] = 8'(i + 1);
         end
         mst.stop;
         idle;
         rd(8'h03, 8'h10, 16);
         for (i = 0; i < 16; i = i + 1) cmp(got[i], ref_pg[i]);
         rd(8'h03, 8'hFF, 3);
         cmp(got[1], 8'h5A);
         cmp(got[2], 8'hFF);
      end
   endtask
   task t_guard;
      begin
         wen;
         wr(8'h01, 8'hF7, 8'h00, 2);
         rd(8'h05, 8'h00, 0);
         cmp(q, 8'h84);
         wen;
         wr(8'h02, 8'hC0, 8'h11, 3);
         wen;
         wr(8'h02, 8'hBF, 8'h22, 3);
         rd(8'h03, 8'hBF, 2);
         cmp(got[0], 8'h22);
         cmp(got[1], 8'hFF);
         wp_n = 1'b0;
         wen;
         wr(8'h01, 8'h00, 8'h00, 2);
         rd(8'h05, 8'h00, 0);
         cmp(q & 8'hFD, 8'h84);
         wen;
         wr(8'h02, 8'h05, 8'h33, 3);
         rd(8'h03, 8'h05, 1);
         cmp(got[0], 8'h33);
         wp_n = 1'b1;
         wen;
         wr(8'h01, 8'h00, 8'h00, 2);
         rd(8'h05, 8'h00, 0);
         cmp(q, 8'h00);
      end
   endtask
   task t_id;
      begin
         wen;
         wr(8'h82, 8'h03, 8'hA5, 3);
         rd(8'h83, 8'h73, 1);
         cmp(got[0], 8'hA5);
         rd(8'h83, 8'h80, 1);
         cmp(got[0], 8'h00);
         wen;
         wr(8'h82, 8'h80, 8'h02, 3);
         cmp({7'h00, id_locked}, 8'h01);
         rd(8'h83, 8'h80, 1);
         cmp(got[0], 8'h01);
      end
   endtask
   // reset, then the scenarios in turn
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      wp_n = 1'b1;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      repeat (8) @(negedge clk);
      cmp({5'h00, so_oe, busy, id_locked}, 8'h00);
      t_latch;
      t_write;
      t_page;
      t_guard;
      t_id;
      conclude;
   end
endmodule // see_front_test
bind see_front see_front_props #(.TWR_CYCLES(TWR_CYCLES)) u_props (.CLK(CLK), .RSTN(RSTN),
   .CS_N(CS_N), .SCK(SCK), .SI(SI), .SO(SO), .SO_OE(SO_OE), .WP_N(WP_N), .BUSY(BUSY),
   .ID_LOCKED(ID_LOCKED));
